// ===== hdl/hfm_defines.svh
// Register offsets, field positions, reset values and fixed counts of the HDLC FIFO block.
// Assumes one host port per block; controller select is the top address bit above these.
`ifndef HFM_DEFINES_SVH
`define HFM_DEFINES_SVH
// Per-controller register offsets (five address bits).
`define HFM_OFS_TX_CTRL 5'h00
`define HFM_OFS_RX_CTRL 5'h01
`define HFM_OFS_FIFO_WM 5'h02
`define HFM_OFS_STATUS 5'h03
`define HFM_OFS_IRQ_MASK 5'h04
`define HFM_OFS_PKT_INFO 5'h05
`define HFM_OFS_RX_COUNT 5'h06
`define HFM_OFS_TX_SPACE 5'h07
`define HFM_OFS_RX_CS1 5'h08
`define HFM_OFS_RX_CS2 5'h09
`define HFM_OFS_RX_CS3 5'h0A
`define HFM_OFS_RX_CS4 5'h0B
`define HFM_OFS_TX_CS1 5'h0C
`define HFM_OFS_TX_CS2 5'h0D
`define HFM_OFS_TX_CS3 5'h0E
`define HFM_OFS_TX_CS4 5'h0F
`define HFM_OFS_RX_BITSEL 5'h10
`define HFM_OFS_TX_BITSEL 5'h11
`define HFM_OFS_RX_FIFO 5'h12
`define HFM_OFS_TX_FIFO 5'h13
`define HFM_OFS_TX_FIFO_LAST 5'h14
// Field positions.
`define HFM_CTRL_RESET_BIT 0
`define HFM_WM_TX_MSB 5
`define HFM_WM_TX_LSB 3
`define HFM_WM_RX_MSB 2
`define HFM_WM_RX_LSB 0
`define HFM_ST_TX_LOW_WATERMARK_FLAG 0
`define HFM_ST_RX_HIGH_WATERMARK_FLAG 1
`define HFM_ST_RPE 2
// Reset value of every writable register.
`define HFM_REG_RESET 8'h00
// Packet status codes.
`define HFM_PS_PROGRESS 3'h0
`define HFM_PS_OK 3'h1
`define HFM_PS_CRC 3'h2
`define HFM_PS_ABORT 3'h3
`define HFM_PS_OVF 3'h4
// FIFO depth in bytes and fixed HDLC constants.
`define HFM_FIFO_DEPTH 128
`define HFM_COUNT_MAX 7'h7F
`define HFM_CRC_INIT 16'hFFFF
`define HFM_CRC_POLY 16'h8408
`define HFM_CRC_GOOD 16'hF0B8
`define HFM_FLAG 8'h7E
`define HFM_ABORT 8'hFF
`define HFM_LQ_FULL 3'h4
`endif

// ===== hdl/hfm_pkg.sv
// Types shared by the HDLC FIFO block: mapping modes, stream slots, FIFO words, states.
// Assumes the defines header supplies all numeric constants.
package hfm_pkg;
	// Where a controller sits in the frame; the code equals the control register field.
	typedef enum logic [1:0] {HFM_MAP_CHAN, HFM_MAP_FDL, HFM_MAP_SPARE, HFM_MAP_OFF} hfm_map_t;
	// Kind of bit the framer is offering in a stream slot.
	typedef enum logic [1:0] {HFM_SK_CHAN, HFM_SK_FDL, HFM_SK_SPARE, HFM_SK_OTHER} hfm_slot_kind_t;
	// One stream slot: kind, zero-based channel, bit position or spare bit index.
	typedef struct packed {
		hfm_slot_kind_t kind;
		logic [4:0] chan;
		logic [2:0] pos;
	} hfm_slot_t;
	// Transmit FIFO word: payload byte plus end-of-message marker.
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} hfm_txw_t;
	// Record of one ended receive packet.
	typedef struct packed {
		logic [2:0] status;
		logic [11:0] len;
	} hfm_pkt_t;
	// Transmit serialiser states.
	typedef enum logic [2:0] {HFM_TX_FLAG, HFM_TX_DATA, HFM_TX_CRC_LO, HFM_TX_CRC_HI,
		HFM_TX_ABORT} hfm_tx_state_t;
endpackage

// ===== hdl/hfm_top.sv
// Two HDLC controllers with 128-byte FIFOs, channel/bit mapping and packet reporting.
// Assumes host strobes and the framer slot stream are synchronous logic on i_clock.
// Operation
// - Watermark register: tx bits 5:3, rx 2:0.
// - Tx low-watermark flag live, can interrupt.
// - Rx high-watermark flag live, can interrupt.
// - 128-byte tx and rx FIFOs, own ports.
// - Map to data link, spare bits, channels.
// - Unselected bits inside mapped channels skipped.
// - Four rx channel-select registers, eight each.
// - Four tx channel-select registers, eight each.
// - Bit-select picks channel bits or spare bits.
// - Tx space register reports free bytes.
// - Rx count low seven bits, 0-127.
// - Count top bit set while packet unfinished.
// - Packet status codes progress/ok/crc/abort/overflow.
// - Mask register gates status onto interrupt.
// - Control registers reset their own direction.
// - Flags, aborts, CRC, zero stuffing, alignment.
// - Two identical controllers, separate registers.

// Plain synchronous FIFO in flip-flops; full and empty are exact.
module hfm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_flush,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data,
	output logic [AW:0] o_level
);
	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage, no reset needed.
	logic [AW-1:0] wr_ptr_reg; // Next slot to write.
	logic [AW-1:0] rd_ptr_reg; // Oldest entry.
	logic [AW:0] level_reg; // Entries held.
	logic push; // Accepted write.
	logic pop; // Accepted read.
	assign o_ready = level_reg != (AW+1)'(DEPTH);
	assign o_valid = level_reg != '0;
	assign o_data = mem_reg[rd_ptr_reg];
	assign o_level = level_reg;
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	// Write the storage array.
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_data;
		end
	end
	// Pointers wrap on their own because the depth is a power of two.
	always_ff @(posedge i_clock) begin
		if (i_rst || i_flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			level_reg <= level_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// One HDLC controller: registers, receive deframer, transmit framer, packet bookkeeping.
module hfm_ctrl import hfm_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_sel,
	input wire logic [4:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic i_rx_strobe,
	input wire hfm_slot_t i_rx_slot,
	input wire logic i_rx_bit,
	input wire logic i_tx_strobe,
	input wire hfm_slot_t i_tx_slot,
	output logic o_tx_bit,
	output logic o_tx_valid,
	output logic o_irq
);
	`include "hfm_defines.svh"
	logic [7:0] tx_ctrl_reg, rx_ctrl_reg, wm_reg, mask_reg, rx_bs_reg, tx_bs_reg;
	logic [7:0] rx_cs_reg [4]; // Channels 1-8, 9-16, 17-24, 25-32.
	logic [7:0] tx_cs_reg [4]; // Same grouping for transmit.
	logic wr, rd, tx_rst, rx_rst; // Decoded host strobes.
	logic [7:0] rx_level, tx_level, tx_space, rx_count, hdlc_status, pkt_info;
	// Receive deframer state.
	logic [2:0] rx_ones_reg, rx_bits_reg;
	logic [1:0] rx_held_reg;
	logic [7:0] rx_sh_reg, hold0_reg, hold1_reg;
	logic rx_in_frame_reg, rx_drop_reg;
	logic [15:0] rx_crc_reg;
	logic [11:0] rx_len_reg, consumed_reg, rem;
	logic rx_go, rx_flag, rx_abort, rx_data, rx_push, rx_ovf, rxf_ready, rxf_pop;
	logic [7:0] rx_byte;
	logic [7:0] rxf_data; // Head byte of the receive FIFO, shown before it is popped.
	// Ended-packet queue.
	hfm_pkt_t lq_reg [4];
	hfm_pkt_t enq_pkt;
	logic [1:0] lq_wr_reg, lq_rd_reg;
	logic [2:0] lq_cnt_reg;
	logic enq, deq;
	// Transmit framer state.
	hfm_tx_state_t tx_st_reg;
	logic [7:0] tx_sh_reg;
	logic [2:0] tx_cnt_reg, tx_ones_reg;
	logic [15:0] tx_crc_reg;
	logic tx_last_reg, tx_go, txf_valid, txf_pop, txf_push;
	hfm_txw_t txf_word;

	// Byte-wise CRC-16 over LSB-first bits; shared by both directions.
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `HFM_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
	// Whether a stream slot belongs to this controller in this direction.
	function automatic logic slot_used(input hfm_map_t m, input logic [31:0] cs,
		input logic [7:0] bs, input hfm_slot_t s);
		case (m)
			HFM_MAP_CHAN: slot_used = (s.kind == HFM_SK_CHAN) && cs[s.chan] && bs[s.pos];
			HFM_MAP_FDL: slot_used = s.kind == HFM_SK_FDL;
			HFM_MAP_SPARE: slot_used = (s.kind == HFM_SK_SPARE) && bs[s.pos];
			default: slot_used = 1'b0;
		endcase
	endfunction
	// Watermark setting to FIFO level: sixteen bytes per step.
	function automatic logic [7:0] wm_level(input logic [2:0] s);
		return {1'b0, s, 4'h0};
	endfunction
	// Count saturated to the seven-bit field.
	function automatic logic [6:0] sat7(input logic [11:0] v);
		return (v > 12'(`HFM_COUNT_MAX)) ? `HFM_COUNT_MAX : v[6:0];
	endfunction

	assign wr = i_sel && i_wr;
	assign rd = i_sel && i_rd;
	assign tx_rst = wr && (i_addr == `HFM_OFS_TX_CTRL) && i_wdata[`HFM_CTRL_RESET_BIT];
	assign rx_rst = wr && (i_addr == `HFM_OFS_RX_CTRL) && i_wdata[`HFM_CTRL_RESET_BIT];

	// Configuration registers; the reset bit never stores, it only pulses.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			tx_ctrl_reg <= `HFM_REG_RESET;
			rx_ctrl_reg <= `HFM_REG_RESET;
			wm_reg <= `HFM_REG_RESET;
			mask_reg <= `HFM_REG_RESET;
			rx_bs_reg <= `HFM_REG_RESET;
			tx_bs_reg <= `HFM_REG_RESET;
			rx_cs_reg <= '{default: `HFM_REG_RESET};
			tx_cs_reg <= '{default: `HFM_REG_RESET};
		end else if (wr) begin
			// Channel-select groups sit on four-aligned offsets, so the low bits index them.
			case (i_addr)
				`HFM_OFS_TX_CTRL: tx_ctrl_reg <= {i_wdata[7:1], 1'b0};
				`HFM_OFS_RX_CTRL: rx_ctrl_reg <= {i_wdata[7:1], 1'b0};
				`HFM_OFS_FIFO_WM: wm_reg <= i_wdata;
				`HFM_OFS_IRQ_MASK: mask_reg <= i_wdata;
				`HFM_OFS_RX_CS1, `HFM_OFS_RX_CS2, `HFM_OFS_RX_CS3, `HFM_OFS_RX_CS4: begin
					rx_cs_reg[i_addr[1:0]] <= i_wdata;
				end
				`HFM_OFS_TX_CS1, `HFM_OFS_TX_CS2, `HFM_OFS_TX_CS3, `HFM_OFS_TX_CS4: begin
					tx_cs_reg[i_addr[1:0]] <= i_wdata;
				end
				`HFM_OFS_RX_BITSEL: rx_bs_reg <= i_wdata;
				`HFM_OFS_TX_BITSEL: tx_bs_reg <= i_wdata;
				default: ;
			endcase
		end
	end

	// Receive slot decode: flag is 0 after six ones, abort is a seventh one.
	always_comb begin
		rx_go = i_rx_strobe && slot_used(hfm_map_t'(rx_ctrl_reg[2:1]),
			{rx_cs_reg[3], rx_cs_reg[2], rx_cs_reg[1], rx_cs_reg[0]}, rx_bs_reg, i_rx_slot);
		rx_flag = rx_go && !i_rx_bit && (rx_ones_reg == 3'h6);
		rx_abort = rx_go && i_rx_bit && (rx_ones_reg == 3'h6);
		rx_data = rx_go && !rx_flag && !rx_abort && !(!i_rx_bit && (rx_ones_reg == 3'h5));
		rx_byte = {i_rx_bit, rx_sh_reg[7:1]};
		// The last two bytes are held back: at the closing flag they are the FCS.
		rx_push = rx_data && (rx_bits_reg == 3'h7) && rx_in_frame_reg && !rx_drop_reg
			&& (rx_held_reg == 2'h2);
		rx_ovf = rx_push && !rxf_ready;
		enq = (rx_ovf || ((rx_flag || rx_abort) && rx_in_frame_reg && !rx_drop_reg
			&& (rx_len_reg != '0 || rx_held_reg != '0))) && (lq_cnt_reg != `HFM_LQ_FULL);
		enq_pkt.len = rx_len_reg;
		if (rx_ovf) begin
			enq_pkt.status = `HFM_PS_OVF;
		end else if (rx_abort) begin
			enq_pkt.status = `HFM_PS_ABORT;
		end else if ((rx_held_reg == 2'h2) && (rx_bits_reg == 3'h7)
			&& (rx_crc_reg == `HFM_CRC_GOOD)) begin
			enq_pkt.status = `HFM_PS_OK;
		end else begin
			enq_pkt.status = `HFM_PS_CRC;
		end
	end

	// Receive deframer: destuffing, byte alignment from each flag, CRC check.
	always_ff @(posedge i_clock) begin
		if (i_rst || rx_rst) begin
			rx_ones_reg <= '0;
			rx_bits_reg <= '0;
			rx_held_reg <= '0;
			rx_sh_reg <= '0;
			hold0_reg <= '0;
			hold1_reg <= '0;
			rx_in_frame_reg <= 1'b0;
			rx_drop_reg <= 1'b0;
			rx_crc_reg <= `HFM_CRC_INIT;
			rx_len_reg <= '0;
		end else if (rx_go) begin
			rx_ones_reg <= !i_rx_bit ? 3'h0 : (rx_ones_reg == 3'h7) ? 3'h7 : rx_ones_reg + 3'h1;
			if (rx_flag) begin
				// A flag aligns the byte counter and opens a fresh packet.
				rx_in_frame_reg <= 1'b1;
				rx_drop_reg <= 1'b0;
				rx_bits_reg <= '0;
				rx_held_reg <= '0;
				rx_len_reg <= '0;
				rx_crc_reg <= `HFM_CRC_INIT;
			end else if (rx_abort) begin
				rx_in_frame_reg <= 1'b0;
			end else if (rx_data) begin
				rx_sh_reg <= rx_byte;
				rx_bits_reg <= rx_bits_reg + 3'h1;
				if (rx_bits_reg == 3'h7) begin
					rx_crc_reg <= crc_byte(rx_crc_reg, rx_byte);
					hold1_reg <= rx_byte;
					hold0_reg <= hold1_reg;
					if (rx_held_reg != 2'h2) begin
						rx_held_reg <= rx_held_reg + 2'h1;
					end
					// A full FIFO ends the packet as overflowed; the rest is dropped.
					if (rx_push && rxf_ready) begin
						rx_len_reg <= rx_len_reg + 12'h001;
					end else if (rx_ovf) begin
						rx_drop_reg <= 1'b1;
					end
				end
			end
		end
	end

	hfm_fifo #(.WIDTH(8), .DEPTH(`HFM_FIFO_DEPTH)) u_rx_fifo (
		.i_clock(i_clock), .i_rst(i_rst), .i_flush(rx_rst),
		.i_valid(rx_push), .o_ready(rxf_ready), .i_data(hold0_reg),
		.o_valid(), .i_ready(rxf_pop), .o_data(rxf_data), .o_level(rx_level)
	);
	assign rxf_pop = rd && (i_addr == `HFM_OFS_RX_FIFO);

	// Ended-packet queue storage; only four records fit, later ones are lost.
	always_ff @(posedge i_clock) begin
		if (enq) begin
			lq_reg[lq_wr_reg] <= enq_pkt;
		end
	end
	// Queue pointers and bytes of the head packet already read by the host.
	always_ff @(posedge i_clock) begin
		if (i_rst || rx_rst) begin
			lq_wr_reg <= '0;
			lq_rd_reg <= '0;
			lq_cnt_reg <= '0;
			consumed_reg <= '0;
		end else begin
			lq_wr_reg <= lq_wr_reg + 2'(enq);
			lq_rd_reg <= lq_rd_reg + 2'(deq);
			lq_cnt_reg <= lq_cnt_reg + 3'(enq) - 3'(deq);
			if (deq) begin
				consumed_reg <= '0;
			end else if (rxf_pop && rx_level != '0) begin
				consumed_reg <= consumed_reg + 12'h001;
			end
		end
	end

	// Reporting: byte count up to the end of the head packet, then its status.
	always_comb begin
		rem = lq_reg[lq_rd_reg].len - consumed_reg;
		if (lq_cnt_reg != '0) begin
			rx_count = {rem > 12'(`HFM_COUNT_MAX), sat7(rem)};
		end else begin
			rx_count = {1'b1, sat7({4'h0, rx_level})};
		end
		deq = rd && (i_addr == `HFM_OFS_PKT_INFO) && (lq_cnt_reg != '0) && (rem == '0);
		pkt_info = {5'h00, ((lq_cnt_reg != '0) && (rem == '0)) ? lq_reg[lq_rd_reg].status
			: `HFM_PS_PROGRESS};
		tx_space = 8'(`HFM_FIFO_DEPTH) - tx_level;
		hdlc_status = '0;
		hdlc_status[`HFM_ST_TX_LOW_WATERMARK_FLAG] = tx_level < wm_level(wm_reg[`HFM_WM_TX_MSB:`HFM_WM_TX_LSB]);
		hdlc_status[`HFM_ST_RX_HIGH_WATERMARK_FLAG] = rx_level > wm_level(wm_reg[`HFM_WM_RX_MSB:`HFM_WM_RX_LSB]);
		hdlc_status[`HFM_ST_RPE] = lq_cnt_reg != '0;
		o_irq = |(hdlc_status & mask_reg);
	end

	// Host read multiplexer; the receive FIFO port reads the head byte before it is popped.
	always_comb begin
		case (i_addr)
			`HFM_OFS_TX_CTRL: o_rdata = tx_ctrl_reg;
			`HFM_OFS_RX_CTRL: o_rdata = rx_ctrl_reg;
			`HFM_OFS_FIFO_WM: o_rdata = wm_reg;
			`HFM_OFS_STATUS: o_rdata = hdlc_status;
			`HFM_OFS_IRQ_MASK: o_rdata = mask_reg;
			`HFM_OFS_PKT_INFO: o_rdata = pkt_info;
			`HFM_OFS_RX_COUNT: o_rdata = rx_count;
			`HFM_OFS_TX_SPACE: o_rdata = tx_space;
			`HFM_OFS_RX_CS1, `HFM_OFS_RX_CS2, `HFM_OFS_RX_CS3, `HFM_OFS_RX_CS4: begin
				o_rdata = rx_cs_reg[i_addr[1:0]];
			end
			`HFM_OFS_TX_CS1, `HFM_OFS_TX_CS2, `HFM_OFS_TX_CS3, `HFM_OFS_TX_CS4: begin
				o_rdata = tx_cs_reg[i_addr[1:0]];
			end
			`HFM_OFS_RX_BITSEL: o_rdata = rx_bs_reg;
			`HFM_OFS_TX_BITSEL: o_rdata = tx_bs_reg;
			`HFM_OFS_RX_FIFO: o_rdata = rxf_data;
			default: o_rdata = 8'h00;
		endcase
	end

	// Transmit FIFO; writes when full are dropped, software watches the space count.
	assign txf_push = wr && ((i_addr == `HFM_OFS_TX_FIFO) || (i_addr == `HFM_OFS_TX_FIFO_LAST));
	hfm_fifo #(.WIDTH(9), .DEPTH(`HFM_FIFO_DEPTH)) u_tx_fifo (
		.i_clock(i_clock), .i_rst(i_rst), .i_flush(tx_rst),
		.i_valid(txf_push), .o_ready(), .i_data({i_addr == `HFM_OFS_TX_FIFO_LAST, i_wdata}),
		.o_valid(txf_valid), .i_ready(txf_pop), .o_data(txf_word), .o_level(tx_level)
	);
	assign tx_go = i_tx_strobe && slot_used(hfm_map_t'(tx_ctrl_reg[2:1]),
		{tx_cs_reg[3], tx_cs_reg[2], tx_cs_reg[1], tx_cs_reg[0]}, tx_bs_reg, i_tx_slot);
	assign txf_pop = tx_go && (tx_ones_reg != 3'h5) && (tx_cnt_reg == 3'h0) && txf_valid
		&& ((tx_st_reg == HFM_TX_FLAG) || (tx_st_reg == HFM_TX_DATA && !tx_last_reg));

	// Transmit framer: flags between packets, CRC after the last byte, abort on underrun.
	always_ff @(posedge i_clock) begin
		if (i_rst || tx_rst) begin
			tx_st_reg <= HFM_TX_FLAG;
			tx_sh_reg <= `HFM_FLAG;
			tx_cnt_reg <= 3'h7;
			tx_ones_reg <= '0;
			tx_crc_reg <= `HFM_CRC_INIT;
			tx_last_reg <= 1'b0;
			o_tx_bit <= 1'b0;
			o_tx_valid <= 1'b0;
		end else begin
			o_tx_valid <= tx_go;
			if (tx_go && tx_ones_reg == 3'h5) begin
				// Five payload ones sent: insert a zero whatever comes next.
				o_tx_bit <= 1'b0;
				tx_ones_reg <= '0;
			end else if (tx_go) begin
				o_tx_bit <= tx_sh_reg[0];
				tx_ones_reg <= (tx_sh_reg[0] && tx_st_reg != HFM_TX_FLAG
					&& tx_st_reg != HFM_TX_ABORT) ? tx_ones_reg + 3'h1 : 3'h0;
				tx_sh_reg <= tx_sh_reg >> 1;
				tx_cnt_reg <= tx_cnt_reg - 3'h1;
				if (tx_cnt_reg == 3'h0) begin
					if (txf_pop) begin
						tx_st_reg <= HFM_TX_DATA;
						tx_sh_reg <= txf_word.data;
						tx_last_reg <= txf_word.last;
						tx_crc_reg <= crc_byte((tx_st_reg == HFM_TX_FLAG) ? `HFM_CRC_INIT
							: tx_crc_reg, txf_word.data);
					end else if (tx_st_reg == HFM_TX_DATA && tx_last_reg) begin
						tx_st_reg <= HFM_TX_CRC_LO;
						tx_sh_reg <= ~tx_crc_reg[7:0];
					end else if (tx_st_reg == HFM_TX_DATA) begin
						// Underrun inside a packet: the far end must see an abort.
						tx_st_reg <= HFM_TX_ABORT;
						tx_sh_reg <= `HFM_ABORT;
					end else if (tx_st_reg == HFM_TX_CRC_LO) begin
						tx_st_reg <= HFM_TX_CRC_HI;
						tx_sh_reg <= ~tx_crc_reg[15:8];
					end else begin
						tx_st_reg <= HFM_TX_FLAG;
						tx_sh_reg <= `HFM_FLAG;
					end
				end
			end
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_tx_low_watermark_flag;
		tx_space > (8'(`HFM_FIFO_DEPTH) - wm_level(wm_reg[5:3])) |-> hdlc_status[0];
	endproperty
	a_tx_low_watermark_flag: assert property (p_tx_low_watermark_flag) else $error("tx low watermark flag missing");
	property p_rx_high_watermark_flag;
		hdlc_status[1] == (rx_level > {1'b0, wm_reg[2:0], 4'h0});
	endproperty
	a_rx_high_watermark_flag: assert property (p_rx_high_watermark_flag) else $error("rx high watermark flag missing");
	property p_irq;
		(mask_reg == 8'h00) |-> !o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("masked status raised interrupt");
	property p_count;
		rx_count[6:0] <= rx_level[6:0] || rx_level == 8'h80;
	endproperty
	a_count: assert property (p_count) else $error("rx count exceeds FIFO level");
	property p_msb;
		(lq_cnt_reg == 3'h0) |-> rx_count[7];
	endproperty
	a_msb: assert property (p_msb) else $error("count top bit clear mid packet");
	property p_ps;
		pkt_info[2:0] <= 3'h4;
	endproperty
	a_ps: assert property (p_ps) else $error("illegal packet status code");
	property p_txw;
		txf_push && tx_space != 8'h00 && !txf_pop && !tx_rst |=> tx_space == $past(tx_space) - 8'h01;
	endproperty
	a_txw: assert property (p_txw) else $error("tx FIFO write not appended");
	property p_rxr;
		rxf_pop && rx_level != 8'h00 && !rx_push && !rx_rst |=> rx_level == $past(rx_level) - 8'h01;
	endproperty
	a_rxr: assert property (p_rxr) else $error("rx FIFO read did not remove byte");
	property p_rst;
		tx_rst |=> (tx_space == 8'h80) && (tx_st_reg == HFM_TX_FLAG) ##1 !o_tx_bit || !o_tx_valid;
	endproperty
	a_rst: assert property (p_rst) else $error("tx reset did not clear controller");
	property p_stuff;
		tx_go && tx_ones_reg == 3'h5 && !tx_rst |=> o_tx_valid && !o_tx_bit;
	endproperty
	a_stuff: assert property (p_stuff) else $error("zero not inserted after five ones");
	property p_map;
		o_tx_valid |-> $past(tx_go);
	endproperty
	a_map: assert property (p_map) else $error("tx bit sent in unmapped slot");
	c_good: cover property (enq && enq_pkt.status == 3'h1);
	c_ovf: cover property (enq && enq_pkt.status == 3'h4);
	c_tx_low_watermark_flag: cover property (hdlc_status[0] && mask_reg[0]);
	c_crc: cover property (tx_st_reg == HFM_TX_CRC_HI);
endmodule

// Top: two identical controllers selected by address bit 5, shared stream and interrupt.
module hfm_top import hfm_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [5:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic i_rx_strobe,
	input wire hfm_slot_t i_rx_slot,
	input wire logic i_rx_bit,
	input wire logic i_tx_strobe,
	input wire hfm_slot_t i_tx_slot,
	output logic o_tx_bit,
	output logic o_tx_valid,
	output logic o_irq
);
	logic [7:0] rdata [2]; // Per-controller read value.
	logic [1:0] tx_bit, tx_valid, irq; // Per-controller outputs.
	// Both controllers are the same module with their own registers.
	for (genvar g = 0; g < 2; g++) begin : g_ctrl
		hfm_ctrl u_ctrl (
			.i_clock(i_clock), .i_rst(i_rst), .i_sel(i_addr[5] == 1'(g)),
			.i_addr(i_addr[4:0]), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
			.o_rdata(rdata[g]), .i_rx_strobe(i_rx_strobe), .i_rx_slot(i_rx_slot),
			.i_rx_bit(i_rx_bit), .i_tx_strobe(i_tx_strobe), .i_tx_slot(i_tx_slot),
			.o_tx_bit(tx_bit[g]), .o_tx_valid(tx_valid[g]), .o_irq(irq[g])
		);
	end
	// Overlapping transmit maps would collide here; software keeps them apart.
	assign o_tx_bit = |(tx_bit & tx_valid);
	assign o_tx_valid = |tx_valid;
	assign o_irq = |irq;
	// Read data is registered one cycle after the strobe and holds until the next read.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rdata[i_addr[5]];
		end
	end
endmodule

// ===== dv/hfm_framer_model.sv
// Framer stand-in: offers transmit slots of the kind on i_kind, channel field 0, and loops each sent bit back as receive.
// Assumes one clock; slots are offered every second cycle while i_run is high.
module hfm_framer_model import hfm_pkg::*; (
	input wire logic i_clock,
	input wire logic i_run,
	input wire hfm_slot_kind_t i_kind,
	output logic o_tx_strobe,
	output hfm_slot_t o_tx_slot,
	input wire logic i_tx_bit,
	input wire logic i_tx_valid,
	output logic o_rx_strobe,
	output hfm_slot_t o_rx_slot,
	output logic o_rx_bit
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt = 4'h0; // Low bit is the phase, upper bits the bit position.
	initial begin
		o_tx_strobe = 1'b0;
		o_tx_slot = '0;
		o_rx_strobe = 1'b0;
		o_rx_slot = '0;
		o_rx_bit = 1'b0;
	end
	// Everything moves on the falling edge, so the design samples settled values.
	always @(negedge i_clock) begin
		cnt <= cnt + 4'h1;
		o_tx_strobe <= i_run && !cnt[0];
		o_tx_slot <= '{i_kind, 5'h00, cnt[3:1]};
		if (o_tx_strobe) begin
			o_rx_slot <= o_tx_slot;
		end
		o_rx_strobe <= i_tx_valid;
		// Outside a sent bit the line toggles, so a stale value is never mistaken for data.
		o_rx_bit <= i_tx_valid ? i_tx_bit : ~o_rx_bit;
	end
endmodule

// ===== dv/tb.sv
// Bench for the HDLC FIFO block: registers, watermark interrupt, looped-back packet.
// Assumes the framer model loops transmitted channel bits back into the receiver.
module tb import hfm_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [5:0] addr = 6'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b0;
	hfm_slot_kind_t kind = HFM_SK_CHAN; // Slot kind the framer model offers.
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic tx_strobe, rx_strobe, rx_bit, tx_bit, tx_valid, irq;
	hfm_slot_t tx_slot, rx_slot;
	int num_errors = 0;
	int cmp_count = 0;
	initial begin
		forever #12.5 clock = ~clock;
	end
	hfm_top uut (.i_clock(clock), .i_rst(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
		.i_wdata(wdata), .o_rdata(rdata), .i_rx_strobe(rx_strobe), .i_rx_slot(rx_slot),
		.i_rx_bit(rx_bit), .i_tx_strobe(tx_strobe), .i_tx_slot(tx_slot), .o_tx_bit(tx_bit),
		.o_tx_valid(tx_valid), .o_irq(irq));
	hfm_framer_model framer (.i_clock(clock), .i_run(run), .i_kind(kind), .o_tx_strobe(tx_strobe),
		.o_tx_slot(tx_slot), .i_tx_bit(tx_bit), .i_tx_valid(tx_valid), .o_rx_strobe(rx_strobe),
		.o_rx_slot(rx_slot), .o_rx_bit(rx_bit));
	// Case equality, so an unknown never passes as a match.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(negedge clock);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clock);
		wr = 1'b0;
	endtask
	// Data is taken two falling edges later; it stands until the next read.
	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(negedge clock);
		addr = a;
		rd = 1'b1;
		@(negedge clock);
		rd = 1'b0;
		@(negedge clock);
		d = rdata;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd_reg(a, v);
		check(v, exp);
	endtask
	task automatic test_reset_values();
		rd_chk(6'h02, 8'h00);
		rd_chk(6'h07, 8'h80);
		rd_chk(6'h06, 8'h80);
		rd_chk(6'h1F, 8'h00);
		rd_chk(6'h05, 8'h00);
		wr_reg(6'h0B, 8'h5A);
		rd_chk(6'h0B, 8'h5A);
		wr_reg(6'h0F, 8'hC3);
		rd_chk(6'h0F, 8'hC3);
	endtask
	// Tx setting 1 means 16 bytes, so an empty FIFO is below the low watermark.
	task automatic test_watermark();
		wr_reg(6'h02, 8'h08);
		rd_chk(6'h02, 8'h08);
		rd_chk(6'h03, 8'h01);
		check({7'h00, irq}, 8'h00);
		wr_reg(6'h04, 8'h01);
		check({7'h00, irq}, 8'h01);
		rd_chk(6'h22, 8'h00);
		wr_reg(6'h13, 8'hA5);
		rd_chk(6'h07, 8'h7F);
		wr_reg(6'h00, 8'h01);
		rd_chk(6'h07, 8'h80);
		wr_reg(6'h04, 8'h00);
		wr_reg(6'h02, 8'h00);
	endtask
	// Bit position or spare index 7 is left out in both directions.
	// The host waits on the packet-end interrupt and masks it before servicing.
	task automatic test_loopback(input hfm_slot_kind_t k, input logic [7:0] ctl);
		kind = k;
		wr_reg(6'h00, ctl);
		wr_reg(6'h01, ctl);
		wr_reg(6'h0C, 8'h01);
		wr_reg(6'h08, 8'h01);
		wr_reg(6'h11, 8'h7F);
		wr_reg(6'h10, 8'h7F);
		wr_reg(6'h04, 8'h04);
		run = 1'b1;
		repeat (200) @(negedge clock);
		wr_reg(6'h13, 8'h11);
		wr_reg(6'h13, 8'h22);
		wr_reg(6'h14, 8'h33);
		for (int i = 0; i < 5000 && irq !== 1'b1; i++) begin
			@(negedge clock);
		end
		run = 1'b0;
		check({7'h00, irq}, 8'h01);
		wr_reg(6'h04, 8'h00);
		rd_chk(6'h03, 8'h06);
		rd_chk(6'h06, 8'h03);
		rd_chk(6'h12, 8'h11);
		rd_chk(6'h12, 8'h22);
		rd_chk(6'h12, 8'h33);
		rd_chk(6'h05, 8'h01);
		rd_chk(6'h03, 8'h00);
	endtask
	task automatic report_and_stop();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// The tests need well under 10000 cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(negedge clock);
		rst = 1'b0;
		test_reset_values();
		test_watermark();
		test_loopback(HFM_SK_CHAN, 8'h00);
		test_loopback(HFM_SK_SPARE, 8'h04);
		report_and_stop();
	end
endmodule
